// *** verilog/rssd_pkg.sv ***
// Constants, types and decode helpers for the rotate/subtract/sleep decoder
package rssd_pkg;

   // ------------------------------------------------------------------
   // Opcode fields
   // ------------------------------------------------------------------
   localparam int        OPW            = 14;
   localparam logic [5:0] OPC_ROT_LEFT  = 6'h0d;
   localparam logic [5:0] OPC_ROT_RIGHT = 6'h0c;
   localparam logic [5:0] OPC_LIT_SUB   = 6'h1d;
   localparam logic [13:0] OPC_SLEEP    = 14'h0003;
   localparam int        OPC_HI         = 13;
   localparam int        OPC_LO         = 8;
   localparam int        DEST_BIT       = 7;
   localparam int        FADDR_HI       = 6;

   // ------------------------------------------------------------------
   // Register bus map
   // ------------------------------------------------------------------
   localparam logic [7:0] ADDR_FILE_MAX = 8'h7f;
   localparam logic [7:0] ADDR_ACC      = 8'h80;
   localparam logic [7:0] ADDR_STATUS   = 8'h81;
   localparam logic [7:0] ADDR_STATE    = 8'h82;
   localparam logic [7:0] ACC_RST       = 8'h00;
   localparam logic [7:0] FILE_RST      = 8'h00;

   // ------------------------------------------------------------------
   // Status flags, bit 0 is carry
   // ------------------------------------------------------------------
   typedef struct packed {
      logic watchdog_expiry_flag;
      logic powerdown_flag;
      logic zero_flag;
      logic half_carry_flag;
      logic carry_flag;
   } rssd_flags_t;

   localparam rssd_flags_t FLAGS_RST = 5'h18;

   typedef enum logic [2:0] {
      OP_NONE,
      OP_ROT_LEFT,
      OP_ROT_RIGHT,
      OP_LIT_SUB,
      OP_SLEEP
   } rssd_op_t;

   typedef enum logic {
      ST_RUN,
      ST_ASLEEP
   } rssd_state_t;

   // ------------------------------------------------------------------
   // Decoding
   // ------------------------------------------------------------------
   function automatic rssd_op_t rssd_decode(input logic [13:0] opc);
      rssd_op_t op;
      op = OP_NONE;
      if (opc == OPC_SLEEP)
         op = OP_SLEEP;
      else if (opc[OPC_HI:OPC_LO] == OPC_ROT_LEFT)
         op = OP_ROT_LEFT;
      else if (opc[OPC_HI:OPC_LO] == OPC_ROT_RIGHT)
         op = OP_ROT_RIGHT;
      else if (opc[OPC_HI:OPC_LO] == OPC_LIT_SUB)
         op = OP_LIT_SUB;
      return op;
   endfunction

   function automatic logic rssd_is_rotate(input rssd_op_t op);
      return (op == OP_ROT_LEFT) || (op == OP_ROT_RIGHT);
   endfunction

endpackage

// *** verilog/rssd_alu.sv ***
// Result and flag computation for rotate and literal subtract
`timescale 1ns/1ps
module rssd_alu
   import rssd_pkg::*;
(
   input  rssd_op_t     op,
   input  wire logic [7:0] operand,
   input  wire logic [7:0] acc_val,
   input  wire logic [7:0] literal,
   input  rssd_flags_t  flags_in,
   output logic [7:0]   result,
   output rssd_flags_t  flags_out
);

   logic [8:0] diff_byte;
   logic [4:0] diff_nib;

   always_comb begin
      diff_byte = {1'b0, literal} - {1'b0, acc_val};
      diff_nib  = {1'b0, literal[3:0]} - {1'b0, acc_val[3:0]};
      result    = acc_val;
      flags_out = flags_in;
      unique case (op)
         OP_ROT_LEFT: begin
            result               = {operand[6:0], flags_in.carry_flag};
            flags_out.carry_flag = operand[7];
         end
         OP_ROT_RIGHT: begin
            result               = {flags_in.carry_flag, operand[7:1]};
            flags_out.carry_flag = operand[0];
         end
         OP_LIT_SUB: begin
            result                    = diff_byte[7:0];
            flags_out.carry_flag      = ~diff_byte[8];
            flags_out.zero_flag       = (diff_byte[7:0] == 8'h00);
            flags_out.half_carry_flag = ~diff_nib[4];
         end
         OP_SLEEP,
         OP_NONE: begin
            result = acc_val;
         end
      endcase
   end

endmodule

// *** verilog/rssd_core.sv ***
// Decode and execute of rotate, literal subtract and power-down
`timescale 1ns/1ps
// Functional notes
// - Rotate-left shifts file left, carry into bit 0, bit 7 out; 1 cycle.
// - Rotate-right shifts file right, carry into bit 7, bit 0 out; 1 cycle.
// - Rotate file address is opcode bits 6..0; bit 7 selects destination.
// - Destination 0 writes accumulator and leaves file register alone.
// - Destination 1 writes result back into the addressed file register.
// - Rotates change carry only; zero and half-carry keep their values.
// - Power-down opcode stops oscillator, updates timeout and powerdown flags.
// - Literal-minus-acc writes literal minus accumulator to acc in 1 cycle.
// - Subtract sets carry on no borrow, zero only on zero result.
module rssd_core
   import rssd_pkg::*;
#(
   parameter int FILE_DEPTH = 128
)(
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         instr_valid,
   input  wire logic [13:0]  instr,
   input  wire logic         wake_pin,
   input  wire logic [7:0]   bus_addr,
   input  wire logic [7:0]   bus_wdata,
   input  wire logic         bus_wr,
   input  wire logic         bus_rd,
   output logic [7:0]        bus_rdata,
   output logic [7:0]        acc,
   output rssd_flags_t       flags,
   output logic              osc_stop,
   output logic              instr_done
);

   // ------------------------------------------------------------------
   // Storage and state
   // ------------------------------------------------------------------
   logic [7:0]    file_mem [FILE_DEPTH];
   rssd_state_t   state;
   logic          wake_meta;
   logic          wake_sync;

   rssd_op_t      op;
   logic          go;
   logic          dest_file;
   logic [6:0]    faddr;
   logic [7:0]    operand;
   logic [7:0]    alu_result;
   rssd_flags_t   alu_flags;
   logic          bus_file_wr;

   // ------------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------------
   assign op        = rssd_decode(instr);
   assign go        = instr_valid && (state == ST_RUN) && (op != OP_NONE);
   assign faddr     = instr[FADDR_HI:0];
   assign dest_file = instr[DEST_BIT];
   assign operand   = file_mem[faddr];
   assign bus_file_wr = bus_wr && (bus_addr <= ADDR_FILE_MAX);

   rssd_alu u_alu (
      .op        (op),
      .operand   (operand),
      .acc_val   (acc),
      .literal   (instr[7:0]),
      .flags_in  (flags),
      .result    (alu_result),
      .flags_out (alu_flags)
   );

   // ------------------------------------------------------------------
   // Wake pin synchroniser
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wake_meta <= 1'b0;
         wake_sync <= 1'b0;
      end else begin
         wake_meta <= wake_pin;
         wake_sync <= wake_meta;
      end
   end

   // ------------------------------------------------------------------
   // Run and power-down state
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state    <= ST_RUN;
         osc_stop <= 1'b0;
      end else begin
         unique case (state)
            ST_RUN: begin
               if (go && op == OP_SLEEP) begin
                  state    <= ST_ASLEEP;
                  osc_stop <= 1'b1;
               end
            end
            ST_ASLEEP: begin
               if (wake_sync) begin
                  state    <= ST_RUN;
                  osc_stop <= 1'b0;
               end
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Accumulator
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acc <= ACC_RST;
      end else if (go && op == OP_LIT_SUB) begin
         acc <= alu_result;
      end else if (go && rssd_is_rotate(op) && !dest_file) begin
         acc <= alu_result;
      end else if (bus_wr && bus_addr == ADDR_ACC) begin
         acc <= bus_wdata;
      end
   end

   // ------------------------------------------------------------------
   // File registers
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < FILE_DEPTH; i++) begin
            file_mem[i] <= FILE_RST;
         end
      end else begin
         // Bus write to another register still lands
         if (bus_file_wr) begin
            file_mem[bus_addr[6:0]] <= bus_wdata;
         end
         if (go && rssd_is_rotate(op) && dest_file) begin
            file_mem[faddr] <= alu_result;
         end
      end
   end

   // ------------------------------------------------------------------
   // Status flags
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flags <= FLAGS_RST;
      end else if (go && op == OP_SLEEP) begin
         flags.watchdog_expiry_flag <= 1'b1;
         flags.powerdown_flag       <= 1'b0;
      end else if (go) begin
         flags <= alu_flags;
      end else if (bus_wr && bus_addr == ADDR_STATUS) begin
         flags <= rssd_flags_t'(bus_wdata[4:0]);
      end
   end

   // ------------------------------------------------------------------
   // Completion pulse
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         instr_done <= 1'b0;
      end else begin
         instr_done <= go;
      end
   end

   // ------------------------------------------------------------------
   // Register read port
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_rdata <= 8'h00;
      end else if (bus_rd) begin
         if (bus_addr <= ADDR_FILE_MAX)
            bus_rdata <= file_mem[bus_addr[6:0]];
         else if (bus_addr == ADDR_ACC)
            bus_rdata <= acc;
         else if (bus_addr == ADDR_STATUS)
            bus_rdata <= {3'h0, flags};
         else if (bus_addr == ADDR_STATE)
            bus_rdata <= {7'h00, osc_stop};
         else
            bus_rdata <= 8'h00;
      end else begin
         bus_rdata <= 8'h00;
      end
   end

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   property p_rot_left;
      @(posedge clk) disable iff (!rst_n)
      (go && op == OP_ROT_LEFT && !dest_file) |=>
         acc == {$past(operand[6:0]), $past(flags.carry_flag)} &&
         flags.carry_flag == $past(operand[7]);
   endproperty
   a_rot_left: assert property (p_rot_left)
      else $error("rotate left result or carry wrong");

   property p_rot_right;
      @(posedge clk) disable iff (!rst_n)
      (go && op == OP_ROT_RIGHT && !dest_file) |=>
         acc == {$past(flags.carry_flag), $past(operand[7:1])} &&
         flags.carry_flag == $past(operand[0]);
   endproperty
   a_rot_right: assert property (p_rot_right)
      else $error("rotate right result or carry wrong");

   property p_rot_addr;
      @(posedge clk) disable iff (!rst_n)
      (go && rssd_is_rotate(op)) |=>
         flags.carry_flag == (($past(op) == OP_ROT_LEFT) ?
                              $past(file_mem[instr[6:0]][7]) :
                              $past(file_mem[instr[6:0]][0]));
   endproperty
   a_rot_addr: assert property (p_rot_addr)
      else $error("rotate operand from wrong address");

   property p_dest_acc;
      @(posedge clk) disable iff (!rst_n)
      (go && rssd_is_rotate(op) && !dest_file && !bus_file_wr) |=>
         file_mem[$past(faddr)] == $past(operand);
   endproperty
   a_dest_acc: assert property (p_dest_acc)
      else $error("file register changed with acc destination");

   property p_dest_file;
      @(posedge clk) disable iff (!rst_n)
      (go && rssd_is_rotate(op) && dest_file &&
       !(bus_wr && bus_addr == ADDR_ACC)) |=>
         file_mem[$past(faddr)] == (($past(op) == OP_ROT_LEFT) ?
            {$past(operand[6:0]), $past(flags.carry_flag)} :
            {$past(flags.carry_flag), $past(operand[7:1])}) &&
         acc == $past(acc);
   endproperty
   a_dest_file: assert property (p_dest_file)
      else $error("rotate not written back to file register");

   property p_rot_flags;
      @(posedge clk) disable iff (!rst_n)
      (go && rssd_is_rotate(op)) |=>
         $stable(flags.zero_flag) && $stable(flags.half_carry_flag) &&
         $stable(flags.watchdog_expiry_flag) &&
         $stable(flags.powerdown_flag);
   endproperty
   a_rot_flags: assert property (p_rot_flags)
      else $error("rotate changed a flag other than carry");

   property p_rot_done;
      @(posedge clk) disable iff (!rst_n)
      (go && rssd_is_rotate(op)) |=> instr_done;
   endproperty
   a_rot_done: assert property (p_rot_done)
      else $error("rotate did not complete in one cycle");

   property p_asleep_refuse;
      @(posedge clk) disable iff (!rst_n)
      (instr_valid && state == ST_ASLEEP) |=> !instr_done;
   endproperty
   a_asleep_refuse: assert property (p_asleep_refuse)
      else $error("instruction executed during power-down");

   property p_sleep;
      @(posedge clk) disable iff (!rst_n)
      (go && op == OP_SLEEP) |=>
         osc_stop && state == ST_ASLEEP && instr_done &&
         flags.watchdog_expiry_flag && !flags.powerdown_flag &&
         $stable(acc);
   endproperty
   a_sleep: assert property (p_sleep)
      else $error("power-down entry wrong");

   property p_sub_result;
      @(posedge clk) disable iff (!rst_n)
      (go && op == OP_LIT_SUB) |=>
         acc == 8'($past(instr[7:0]) - $past(acc)) && instr_done;
   endproperty
   a_sub_result: assert property (p_sub_result)
      else $error("literal minus acc result wrong");

   property p_sub_flags;
      @(posedge clk) disable iff (!rst_n)
      (go && op == OP_LIT_SUB) |=>
         flags.carry_flag == ($past(instr[7:0]) >= $past(acc)) &&
         flags.zero_flag == ($past(instr[7:0]) == $past(acc));
   endproperty
   a_sub_flags: assert property (p_sub_flags)
      else $error("subtract carry or zero wrong");

   property p_sub_half;
      @(posedge clk) disable iff (!rst_n)
      (go && op == OP_LIT_SUB) |=>
         flags.half_carry_flag == ($past(instr[3:0]) >= $past(acc[3:0]));
   endproperty
   a_sub_half: assert property (p_sub_half)
      else $error("subtract half-carry wrong");

endmodule

// *** tb/rssd_core_tb.sv ***
// Self-checking bench for the rotate/subtract/sleep decoder
`timescale 1ns/1ps
module rssd_core_tb
   import rssd_pkg::*;
;
   // ------------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------------
   logic        clk;
   logic        rst_n;
   logic        instr_valid;
   logic [13:0] instr;
   logic        wake_pin;
   logic [7:0]  bus_addr;
   logic [7:0]  bus_wdata;
   logic        bus_wr;
   logic        bus_rd;
   logic [7:0]  bus_rdata;
   logic [7:0]  acc;
   rssd_flags_t flags;
   logic        osc_stop;
   logic        instr_done;
   int          n_errors;
   int          checks;
   int          cycles;
   logic [7:0]  rd;

   rssd_core #(.FILE_DEPTH(128)) rssd_core_inst (
      .clk         (clk),
      .rst_n       (rst_n),
      .instr_valid (instr_valid),
      .instr       (instr),
      .wake_pin    (wake_pin),
      .bus_addr    (bus_addr),
      .bus_wdata   (bus_wdata),
      .bus_wr      (bus_wr),
      .bus_rd      (bus_rd),
      .bus_rdata   (bus_rdata),
      .acc         (acc),
      .flags       (flags),
      .osc_stop    (osc_stop),
      .instr_done  (instr_done)
   );

   // ------------------------------------------------------------------
   // Clock and watchdog
   // ------------------------------------------------------------------
   initial clk = 1'b0;
   always #12.5 clk = ~clk;

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_errors = n_errors + 1;
         finish_test();
      end
   end

   // ------------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks = checks + 1;
      if (got !== exp) begin
         n_errors = n_errors + 1;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      bus_wr    <= 1'b1;
      bus_addr  <= a;
      bus_wdata <= d;
      @(posedge clk);
      bus_wr    <= 1'b0;
   endtask

   task automatic bus_read(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      bus_rd   <= 1'b1;
      bus_addr <= a;
      @(posedge clk);
      bus_rd   <= 1'b0;
      #1 d = bus_rdata;
   endtask

   task automatic exec(input logic [13:0] op, input logic exp_done);
      @(posedge clk);
      instr_valid <= 1'b1;
      instr       <= op;
      @(posedge clk);
      instr_valid <= 1'b0;
      #1 chk({7'h00, instr_done}, {7'h00, exp_done});
   endtask

   task automatic finish_test();
      $display("checks=%0d n_errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task automatic t_reset();
      chk(acc, ACC_RST);
      chk({3'h0, flags}, {3'h0, FLAGS_RST});
      chk({7'h00, osc_stop}, 8'h00);
      bus_read(8'h05, rd);
      chk(rd, FILE_RST);
      bus_read(ADDR_STATUS, rd);
      chk(rd, {3'h0, FLAGS_RST});
      bus_read(8'h90, rd);
      chk(rd, 8'h00);
   endtask

   task automatic t_rotate();
      bus_write(8'h05, 8'he6);
      bus_write(ADDR_STATUS, 8'h06);
      exec(14'h0d05, 1'b1);
      chk(acc, 8'hcc);
      chk({3'h0, flags}, 8'h07);
      bus_read(8'h05, rd);
      chk(rd, 8'he6);
      bus_write(8'h7f, 8'he6);
      exec(14'h0cff, 1'b1);
      bus_read(8'h7f, rd);
      chk(rd, 8'hf3);
      chk(acc, 8'hcc);
      chk({3'h0, flags}, 8'h06);
      bus_write(8'h00, 8'h81);
      exec(14'h0d80, 1'b1);
      bus_read(8'h00, rd);
      chk(rd, 8'h02);
      chk({3'h0, flags}, 8'h07);
      exec(14'h0c00, 1'b1);
      chk(acc, 8'h81);
      chk({3'h0, flags}, 8'h06);
   endtask

   task automatic sub_case(input logic [7:0] a, input logic [7:0] k);
      logic [7:0] r;
      rssd_flags_t f;
      r = k - a;
      f = '0;
      f.carry_flag = (k >= a);
      f.half_carry_flag = (k[3:0] >= a[3:0]);
      f.zero_flag = (r == 8'h00);
      bus_write(ADDR_STATUS, 8'h00);
      bus_write(ADDR_ACC, a);
      exec({6'h1d, k}, 1'b1);
      chk(acc, r);
      chk({3'h0, flags}, {3'h0, f});
   endtask

   task automatic t_subtract();
      sub_case(8'h10, 8'h15);
      sub_case(8'h10, 8'h10);
      sub_case(8'h10, 8'h05);
      sub_case(8'h0f, 8'h10);
      sub_case(8'h01, 8'hff);
      sub_case(8'h00, 8'h00);
   endtask

   task automatic t_unknown();
      bus_write(ADDR_ACC, 8'h3c);
      exec(14'h0000, 1'b0);
      exec(14'h0e05, 1'b0);
      chk(acc, 8'h3c);
      chk({3'h0, flags}, 8'h07);
      bus_read(ADDR_ACC, rd);
      chk(rd, 8'h3c);
      @(posedge clk);
      #1 chk(bus_rdata, 8'h00);
   endtask

   task automatic t_sleep();
      int n;
      bus_write(ADDR_STATUS, 8'h00);
      exec(OPC_SLEEP, 1'b1);
      chk({7'h00, osc_stop}, 8'h01);
      chk({3'h0, flags}, 8'h10);
      bus_read(ADDR_STATE, rd);
      chk(rd, 8'h01);
      exec(14'h0d05, 1'b0);
      chk(acc, 8'h3c);
      @(posedge clk);
      wake_pin <= 1'b1;
      n = 0;
      while (osc_stop !== 1'b0 && n < 6) begin
         @(posedge clk);
         n = n + 1;
      end
      wake_pin <= 1'b0;
      #1 chk({7'h00, osc_stop}, 8'h00);
      exec(14'h0d05, 1'b1);
      chk(acc, 8'hcc);
   endtask

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      n_errors    = 0;
      checks      = 0;
      cycles      = 0;
      rst_n       = 1'b0;
      instr_valid = 1'b0;
      instr       = 14'h0000;
      wake_pin    = 1'b0;
      bus_addr    = 8'h00;
      bus_wdata   = 8'h00;
      bus_wr      = 1'b0;
      bus_rd      = 1'b0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      t_reset();
      t_rotate();
      t_subtract();
      t_unknown();
      t_sleep();
      finish_test();
   end
endmodule
